// *** hw/stack_cfg_pkg.sv ***
// Shared constants and types for the stack configuration loader
package stack_cfg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] CTRL_OFF = 5'h00;
  localparam logic [4:0] STACK_OFF = 5'h04;
  localparam logic [4:0] CFG_OFF = 5'h08;
  localparam logic [4:0] STATUS_OFF = 5'h0C;
  localparam logic [4:0] MASK_OFF = 5'h10;
  localparam logic [4:0] STATE_OFF = 5'h14;
  localparam logic [4:0] RESP_OFF = 5'h18;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SLAVE_BIT = 1;
  localparam int CTRL_EN_BIT = 2;
  localparam int CTRL_IDX_LSB = 4;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_SYNC_BIT = 6;
  localparam int ST_POR_BIT = 7;
  localparam logic [7:0] STACK_RST = 8'h02;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [7:0] MASK_RST = 8'h00;

  // ----------------------------------------------------------------
  // Back-channel bytes and bus answers
  // ----------------------------------------------------------------
  localparam logic [3:0] QUERY_NIB = 4'hA;
  localparam logic [7:0] CFG_CMD = 8'hC0;
  localparam logic [1:0] CFG_BYTES = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int MEM_DEPTH = 16;
  localparam int MEM_AW = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESP_TIMEOUT_NS = 10000;
  localparam int SYNC_LOSS_NS = 10000;
  localparam int RESP_TIMEOUT_CYC = RESP_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int SYNC_LOSS_CYC = SYNC_LOSS_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {S_IDLE, S_ASK, S_LISTEN, S_SEND, S_DONE, S_FAULT} load_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } link_byte_t;

endpackage : stack_cfg_pkg

// *** hw/slave_resp_mem.sv ***
// Small memory that keeps the phase answer of each slave
module slave_resp_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4,
  parameter int W = 8
) (
  // Clock
  input wire logic aclk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // Read port, data one cycle after the address
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);

  logic [W-1:0] mem [DEPTH];

  // No reset: contents are only meaningful after a load sequence
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : slave_resp_mem

// *** hw/strap_decode.sv ***
// Strap level quantiser giving bottom resistor and divider codes
module strap_decode (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Converter levels from the strap sense front end
  input wire logic [7:0] bot_level,
  input wire logic [7:0] ratio_level,
  // Decoded codes
  output logic [3:0] bottom_resistor_code,
  output logic [3:0] divider_code
);

  typedef struct packed {
    logic [3:0] bot;
    logic [3:0] div;
  } strap_t;

  strap_t st_q;
  strap_t st_d;

  // Sixteen equal bands; the sense front end centres each resistor in its band
  function automatic logic [3:0] band(input logic [7:0] level);
    band = level[7:4];
  endfunction : band

  always_comb begin
    st_d.bot = band(bot_level);
    st_d.div = band(ratio_level);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bottom_resistor_code = st_q.bot;
  assign divider_code = st_q.div;

  strap_code_a: assert property (@(posedge aclk) disable iff (!aresetn) aresetn |=>
    (bottom_resistor_code == $past(bot_level[7:4]) &&
    divider_code == $past(ratio_level[7:4])))
    else $error("strap codes do not follow levels");

endmodule : strap_decode

// *** hw/stack_strap_config_loader.sv ***
// Stack master power-on configuration loader with AXI4-Lite registers
// Contract
// - Master polls every slave before conversion
// - Phase mismatch sets fault, blocks conversion
// - All answered: forward remaining strap config
// - Strap gives bottom and divider 4-bit codes
// - Block bytes go least significant first
// - Byte k carries bits 8k+7 to 8k
// - Slave flags missing or lost sync
module stack_strap_config_loader (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Strap sense levels
  input wire logic [7:0] strap_bot_level,
  input wire logic [7:0] strap_ratio_level,
  // Sync pin
  input wire logic sync_in,
  // Back channel to the stack
  output logic link_tx_valid,
  output logic [7:0] link_tx_data,
  input wire logic link_tx_ready,
  input wire logic link_rx_valid,
  input wire logic [7:0] link_rx_data,
  // Results
  output logic conv_enable,
  output logic irq,
  output logic [3:0] bottom_resistor_code,
  output logic [3:0] divider_code
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_hold;
    logic w_hold;
    logic aw_ok;
    logic [4:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rpend;
    logic ar_ok;
    logic [4:0] araddr;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic slave_mode;
    logic enable;
    logic [3:0] idx;
    logic [7:0] stack_cfg;
    logic [15:0] cfg;
    logic [7:0] status;
    logic [7:0] mask;
    logic irq;
    stack_cfg_pkg::load_state_t fsm;
    logic [3:0] slave_no;
    logic [10:0] tmo;
    logic [1:0] byte_no;
    logic [23:0] cfg_snap;
    stack_cfg_pkg::link_byte_t tx;
    logic conv;
    logic sync_s1;
    logic sync_s2;
    logic sync_s3;
    logic [10:0] sync_cnt;
    logic present;
    logic en_prev;
  } state_t;

  localparam state_t ST_RST = '{
    awready: 1'b1, wready: 1'b1, arready: 1'b1,
    stack_cfg: stack_cfg_pkg::STACK_RST, cfg: stack_cfg_pkg::CFG_RST,
    mask: stack_cfg_pkg::MASK_RST, fsm: stack_cfg_pkg::S_IDLE, default: '0};
  localparam logic [10:0] TMO_LAST = 11'(stack_cfg_pkg::RESP_TIMEOUT_CYC - 1);
  localparam logic [10:0] SYNC_LOAD = 11'(stack_cfg_pkg::SYNC_LOSS_CYC);

  state_t st_q;
  state_t st_d;
  logic [7:0] mem_rdata;
  logic mem_we;
  logic [3:0] bot_code;
  logic [3:0] div_code;
  logic [23:0] cfg_word;
  logic [7:0] expected;
  logic [7:0] st_set;
  logic [7:0] st_clr;
  logic start;
  logic present_now;

  // Byte k of a block value; byte 0 goes out first
  function automatic logic [7:0] byte_of(input logic [23:0] word, input logic [1:0] k);
    byte_of = word[{k, 3'h0} +: 8];
  endfunction : byte_of

  // Byte-lane merge for a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : merge

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  strap_decode u_strap (
    .aclk(aclk),
    .aresetn(aresetn),
    .bot_level(strap_bot_level),
    .ratio_level(strap_ratio_level),
    .bottom_resistor_code(bot_code),
    .divider_code(div_code)
  );

  slave_resp_mem #(
    .DEPTH(stack_cfg_pkg::MEM_DEPTH),
    .AW(stack_cfg_pkg::MEM_AW),
    .W(8)
  ) u_mem (
    .aclk(aclk),
    .we(mem_we),
    .waddr(st_q.slave_no),
    .wdata(link_rx_data),
    .raddr(st_q.idx),
    .rdata(mem_rdata)
  );

  assign cfg_word = {div_code, bot_code, st_q.cfg};
  assign expected = {st_q.slave_no, st_q.stack_cfg[3:0]};
  assign present_now = (st_q.sync_cnt != 11'h000);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_set = 8'h00;
    st_clr = 8'h00;
    start = 1'b0;
    mem_we = 1'b0;
    // Write channel: one write in flight, address and data in any order
    if (awvalid && st_q.awready) begin
      st_d.awready = 1'b0;
      st_d.aw_hold = 1'b1;
      st_d.awaddr = awaddr[4:0];
      st_d.aw_ok = (awaddr[31:5] == '0) && (awaddr[1:0] == 2'h0);
    end
    if (wvalid && st_q.wready) begin
      st_d.wready = 1'b0;
      st_d.w_hold = 1'b1;
      st_d.wdata = wdata;
      st_d.wstrb = wstrb;
    end
    if (st_q.aw_hold && st_q.w_hold && !st_q.bvalid) begin
      st_d.aw_hold = 1'b0;
      st_d.w_hold = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = stack_cfg_pkg::RESP_OKAY;
      if (!st_q.aw_ok) begin
        st_d.bresp = stack_cfg_pkg::RESP_SLVERR;
      end else begin
        case (st_q.awaddr)
          stack_cfg_pkg::CTRL_OFF: begin
            if (st_q.wstrb[0]) begin
              start = st_q.wdata[stack_cfg_pkg::CTRL_START_BIT];
              st_d.slave_mode = st_q.wdata[stack_cfg_pkg::CTRL_SLAVE_BIT];
              st_d.enable = st_q.wdata[stack_cfg_pkg::CTRL_EN_BIT];
              st_d.idx = st_q.wdata[stack_cfg_pkg::CTRL_IDX_LSB +: 4];
            end
          end
          stack_cfg_pkg::STACK_OFF: begin
            st_d.stack_cfg = 8'(merge({24'h00_0000, st_q.stack_cfg}, st_q.wdata, st_q.wstrb));
          end
          stack_cfg_pkg::CFG_OFF: begin
            st_d.cfg = 16'(merge({16'h0000, st_q.cfg}, st_q.wdata, st_q.wstrb));
          end
          stack_cfg_pkg::STATUS_OFF: begin
            st_clr = st_q.wdata[7:0] & {8{st_q.wstrb[0]}};
          end
          stack_cfg_pkg::MASK_OFF: begin
            st_d.mask = 8'(merge({24'h00_0000, st_q.mask}, st_q.wdata, st_q.wstrb));
          end
          stack_cfg_pkg::STATE_OFF, stack_cfg_pkg::RESP_OFF: begin
            st_d.bresp = stack_cfg_pkg::RESP_OKAY;
          end
          default: begin
            st_d.bresp = stack_cfg_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
    if (st_q.bvalid && bready) begin
      st_d.bvalid = 1'b0;
      st_d.awready = 1'b1;
      st_d.wready = 1'b1;
    end
    // Read channel: data is registered the cycle after the address; the answer memory is read at the CTRL index, not the read address
    if (arvalid && st_q.arready) begin
      st_d.arready = 1'b0;
      st_d.rpend = 1'b1;
      st_d.araddr = araddr[4:0];
      st_d.ar_ok = (araddr[31:5] == '0) && (araddr[1:0] == 2'h0);
    end
    if (st_q.rpend) begin
      st_d.rpend = 1'b0;
      st_d.rvalid = 1'b1;
      st_d.rresp = stack_cfg_pkg::RESP_OKAY;
      st_d.rdata = 32'h0000_0000;
      case (st_q.ar_ok ? st_q.araddr : 5'h1F)
        stack_cfg_pkg::CTRL_OFF:
          st_d.rdata = {24'h00_0000, st_q.idx, 1'b0, st_q.enable, st_q.slave_mode, 1'b0};
        stack_cfg_pkg::STACK_OFF: st_d.rdata = {24'h00_0000, st_q.stack_cfg};
        stack_cfg_pkg::CFG_OFF: st_d.rdata = {8'h00, cfg_word};
        stack_cfg_pkg::STATUS_OFF: st_d.rdata = {24'h00_0000, st_q.status};
        stack_cfg_pkg::MASK_OFF: st_d.rdata = {24'h00_0000, st_q.mask};
        stack_cfg_pkg::STATE_OFF:
          st_d.rdata = {23'h00_0000, st_q.slave_no, st_q.conv, present_now, 3'(st_q.fsm)};
        stack_cfg_pkg::RESP_OFF: st_d.rdata = {24'h00_0000, mem_rdata};
        default: st_d.rresp = stack_cfg_pkg::RESP_SLVERR;
      endcase
    end
    if (st_q.rvalid && rready) begin
      st_d.rvalid = 1'b0;
      st_d.arready = 1'b1;
    end

    // ----------------------------------------------------------------
    // Master load sequence
    // ----------------------------------------------------------------
    unique case (st_q.fsm)
      stack_cfg_pkg::S_IDLE, stack_cfg_pkg::S_DONE, stack_cfg_pkg::S_FAULT: begin
        if (start && !st_d.slave_mode) begin
          st_d.slave_no = 4'h1;
          if (st_q.stack_cfg[3:0] <= 4'h1) begin
            st_d.fsm = stack_cfg_pkg::S_DONE;
            st_set[stack_cfg_pkg::ST_DONE_BIT] = 1'b1;
          end else begin
            st_d.fsm = stack_cfg_pkg::S_ASK;
            st_d.tx = '{valid: 1'b1, data: {stack_cfg_pkg::QUERY_NIB, 4'h1}};
          end
        end
      end
      stack_cfg_pkg::S_ASK: begin
        if (link_tx_ready) begin
          st_d.tx.valid = 1'b0;
          st_d.tmo = 11'h000;
          st_d.fsm = stack_cfg_pkg::S_LISTEN;
        end
      end
      stack_cfg_pkg::S_LISTEN: begin
        st_d.tmo = st_q.tmo + 11'h001;
        if (link_rx_valid) begin
          mem_we = 1'b1;
          if (link_rx_data != expected) begin
            st_set[stack_cfg_pkg::ST_POR_BIT] = 1'b1;
            st_d.fsm = stack_cfg_pkg::S_FAULT;
          end else if (st_q.slave_no == st_q.stack_cfg[3:0] - 4'h1) begin
            st_d.fsm = stack_cfg_pkg::S_SEND;
            st_d.byte_no = 2'h0;
            st_d.cfg_snap = cfg_word;
            st_d.tx = '{valid: 1'b1, data: stack_cfg_pkg::CFG_CMD};
          end else begin
            st_d.slave_no = st_q.slave_no + 4'h1;
            st_d.fsm = stack_cfg_pkg::S_ASK;
            st_d.tx = '{valid: 1'b1, data: {stack_cfg_pkg::QUERY_NIB, st_q.slave_no + 4'h1}};
          end
        end else if (st_q.tmo == TMO_LAST) begin
          // A silent slave is treated as a mismatch: conversion must not start
          st_set[stack_cfg_pkg::ST_POR_BIT] = 1'b1;
          st_d.fsm = stack_cfg_pkg::S_FAULT;
        end
      end
      stack_cfg_pkg::S_SEND: begin
        if (link_tx_ready) begin
          if (st_q.byte_no == stack_cfg_pkg::CFG_BYTES) begin
            st_d.tx.valid = 1'b0;
            st_d.fsm = stack_cfg_pkg::S_DONE;
            st_set[stack_cfg_pkg::ST_DONE_BIT] = 1'b1;
          end else begin
            st_d.tx.data = byte_of(st_q.cfg_snap, st_q.byte_no);
            st_d.byte_no = st_q.byte_no + 2'h1;
          end
        end
      end
    endcase

    // ----------------------------------------------------------------
    // Slave sync watch
    // ----------------------------------------------------------------
    st_d.sync_s1 = sync_in;
    st_d.sync_s2 = st_q.sync_s1;
    st_d.sync_s3 = st_q.sync_s2;
    if (st_q.sync_s2 && !st_q.sync_s3) begin
      st_d.sync_cnt = SYNC_LOAD;
    end else if (present_now) begin
      st_d.sync_cnt = st_q.sync_cnt - 11'h001;
    end
    st_d.present = present_now;
    st_d.en_prev = st_q.enable;
    if (st_q.slave_mode && st_q.enable) begin
      if (!st_q.en_prev && !present_now) begin
        st_set[stack_cfg_pkg::ST_SYNC_BIT] = 1'b1;
      end
      if (st_q.en_prev && st_q.present && !present_now) begin
        st_set[stack_cfg_pkg::ST_SYNC_BIT] = 1'b1;
      end
    end

    // Set beats clear so an event during the clearing write is kept
    st_d.status = (st_q.status & ~st_clr) | st_set;
    st_d.irq = |(st_d.status & st_d.mask);
    if (st_d.slave_mode) begin
      st_d.conv = st_d.enable && present_now && !st_d.status[stack_cfg_pkg::ST_SYNC_BIT];
    end else begin
      st_d.conv = (st_d.fsm == stack_cfg_pkg::S_DONE);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready = st_q.awready;
  assign wready = st_q.wready;
  assign bvalid = st_q.bvalid;
  assign bresp = st_q.bresp;
  assign arready = st_q.arready;
  assign rvalid = st_q.rvalid;
  assign rresp = st_q.rresp;
  assign rdata = st_q.rdata;
  assign link_tx_valid = st_q.tx.valid;
  assign link_tx_data = st_q.tx.data;
  assign conv_enable = st_q.conv;
  assign irq = st_q.irq;
  assign bottom_resistor_code = bot_code;
  assign divider_code = div_code;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  no_early_conv_a: assert property (!st_q.slave_mode && conv_enable |->
    st_q.fsm == stack_cfg_pkg::S_DONE) else $error("conversion before load done");
  mismatch_fault_a: assert property (st_q.fsm == stack_cfg_pkg::S_LISTEN &&
    link_rx_valid && link_rx_data != expected |=> st_q.status[stack_cfg_pkg::ST_POR_BIT] &&
    st_q.fsm == stack_cfg_pkg::S_FAULT && !conv_enable) else $error("mismatch missed");
  fault_hold_a: assert property (st_q.fsm == stack_cfg_pkg::S_FAULT |->
    !conv_enable) else $error("conversion during fault");
  forward_cfg_a: assert property (st_q.fsm == stack_cfg_pkg::S_LISTEN && link_rx_valid &&
    link_rx_data == expected && st_q.slave_no == st_q.stack_cfg[3:0] - 4'h1 |=>
    link_tx_valid && link_tx_data == stack_cfg_pkg::CFG_CMD) else $error("config not sent");
  lsb_first_a: assert property (st_q.fsm == stack_cfg_pkg::S_SEND && link_tx_ready &&
    st_q.byte_no == 2'h0 |=> link_tx_data == st_q.cfg_snap[7:0]) else $error("lsb not first");
  byte_lane_a: assert property (st_q.fsm == stack_cfg_pkg::S_SEND && link_tx_valid &&
    st_q.byte_no != 2'h0 |-> link_tx_data == st_q.cfg_snap[8*(st_q.byte_no-2'h1) +: 8])
    else $error("byte carries wrong bits");
  sync_missing_a: assert property (st_q.slave_mode && st_q.enable && !st_q.en_prev &&
    !present_now |=> st_q.status[stack_cfg_pkg::ST_SYNC_BIT]) else $error("sync fault missed");
  irq_level_a: assert property (irq == |(st_q.status & st_q.mask))
    else $error("interrupt level wrong");
  write_resp_a: assert property (st_q.aw_hold && st_q.w_hold && !bvalid |=> bvalid)
    else $error("write response late");

  load_ok_c: cover property (st_q.fsm == stack_cfg_pkg::S_SEND ##[1:20]
    st_q.fsm == stack_cfg_pkg::S_DONE);
  load_fault_c: cover property (st_q.fsm == stack_cfg_pkg::S_LISTEN ##1
    st_q.fsm == stack_cfg_pkg::S_FAULT);
  sync_fault_c: cover property ($rose(st_q.status[stack_cfg_pkg::ST_SYNC_BIT]));

endmodule : stack_strap_config_loader

// *** verification/stack_peer.sv ***
// Behavioural model of the other stack members on the back channel
module stack_peer (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Settings from the bench
  input wire logic [3:0] phase_count,
  input wire logic corrupt,
  // Back channel
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Byte capture and delayed answers
  // ----------------------------------------------------------------
  logic [7:0] got [$];
  logic [31:0] lfsr = 32'h0bad_5eed;
  logic [7:0] ans = 8'h00;
  int cnt = 0;
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  always @(posedge aclk) begin
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    rx_valid <= 1'b0;
    // Idle data toggles so a design reading it outside a pulse cannot pass by luck
    rx_data <= ~rx_data;
    // Stalls about one cycle in four
    tx_ready <= lfsr[3] | lfsr[4];
    if (!aresetn) begin
      got.delete();
      cnt = 0;
    end else begin
      if (tx_valid && tx_ready) begin
        got.push_back(tx_data);
        if (tx_data[7:4] == stack_cfg_pkg::QUERY_NIB) begin
          cnt = 2 + int'(lfsr[2:0]);
          ans = {tx_data[3:0], phase_count} ^ {7'h00, corrupt};
        end
      end
      if (cnt > 0) begin
        cnt--;
        if (cnt == 0) begin
          rx_valid <= 1'b1;
          rx_data <= ans;
        end
      end
    end
  end
endmodule : stack_peer

// *** verification/stack_strap_config_loader_bench.sv ***
// Self-checking bench for the stack configuration loader
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module stack_strap_config_loader_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sync_in, conv_enable, irq;
  logic link_tx_valid, link_tx_ready, link_rx_valid, corrupt, sync_run;
  logic [31:0] awaddr, wdata, araddr, rdata, d, seed;
  logic [23:0] w;
  logic [3:0] wstrb, bottom_resistor_code, divider_code, pc;
  logic [1:0] bresp, rresp, r;
  logic [7:0] strap_bot_level, strap_ratio_level, link_tx_data, link_rx_data;
  int n_errors = 0;
  int compares = 0;
  int n;
  stack_strap_config_loader stack_strap_config_loader_i (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .strap_bot_level, .strap_ratio_level, .sync_in,
    .link_tx_valid, .link_tx_data, .link_tx_ready, .link_rx_valid, .link_rx_data, .conv_enable,
    .irq, .bottom_resistor_code, .divider_code);
  stack_peer stack_peer_i (.aclk, .aresetn, .phase_count(pc), .corrupt,
    .tx_valid(link_tx_valid), .tx_data(link_tx_data), .tx_ready(link_tx_ready),
    .rx_valid(link_rx_valid), .rx_data(link_rx_data));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  task automatic conclude();
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic tmo();
    n_errors++;
    conclude();
  endtask : tmo
  task automatic rst();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 300; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 300; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask : rd
  task automatic wait_irq(input int lim);
    for (n = 0; n < lim && irq !== 1'b1; n++) @(posedge aclk);
    if (n >= lim) tmo();
    else repeat (2) @(posedge aclk);
  endtask : wait_irq
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Sync pin runs only while a slave scenario asks for it
  always @(posedge aclk) if (sync_run) sync_in <= ~sync_in;
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, sync_in, corrupt, sync_run} = '0;
    {awaddr, wdata, araddr, strap_bot_level, strap_ratio_level, pc} = '0;
    wstrb = 4'hf;
    seed = 32'h51d2_a490;
    rst();
    rd(32'h0000_0004);
    `CHK(d, {24'h00_0000, stack_cfg_pkg::STACK_RST})
    wr(32'h0000_001C, 32'h0000_0000);
    `CHK(r, stack_cfg_pkg::RESP_SLVERR)
    rd(32'h0000_001C);
    `CHK({r, d}, {stack_cfg_pkg::RESP_SLVERR, 32'h0000_0000})
    // Phase counts 1 to 4 answered well, then a stack of three with a bad answer
    for (int p = 1; p <= 5; p++) begin
      rst();
      seed = xs(seed);
      corrupt <= (p == 5);
      pc <= (p == 5) ? 4'h3 : p[3:0];
      strap_bot_level <= (p == 1) ? 8'hff : seed[7:0];
      strap_ratio_level <= (p == 1) ? 8'h00 : seed[15:8];
      wr(32'h0000_0010, 32'h0000_0081);
      wr(32'h0000_0004, {28'h000_0000, pc});
      wr(32'h0000_0008, {16'h0000, seed[31:16]});
      w = {strap_ratio_level[7:4], strap_bot_level[7:4], seed[31:16]};
      `CHK({divider_code, bottom_resistor_code}, w[23:16])
      rd(32'h0000_0008);
      `CHK(d, {8'h00, w})
      wr(32'h0000_0000, 32'h0000_0001);
      if (p > 1) `CHK(conv_enable, 1'b0)
      wait_irq(3000);
      rd(32'h0000_000C);
      if (p < 5) begin
        `CHK({d[7:0], conv_enable}, {8'h01, 1'b1})
        `CHK(stack_peer_i.got.size(), (p > 1) ? p + 3 : 0)
        for (int i = 1; i < p; i++) begin
          `CHK(stack_peer_i.got[i-1], {stack_cfg_pkg::QUERY_NIB, i[3:0]})
        end
        if (p > 1) `CHK({stack_peer_i.got[p+2], stack_peer_i.got[p+1], stack_peer_i.got[p],
          stack_peer_i.got[p-1]}, {w, stack_cfg_pkg::CFG_CMD})
        if (p > 1) begin
          wr(32'h0000_0000, {24'h00_0000, p[3:0] - 4'h1, 4'h0});
          rd(32'h0000_0018);
          `CHK(d, {24'h00_0000, p[3:0] - 4'h1, pc})
        end
      end else begin
        `CHK({d[7:0], conv_enable}, {8'h80, 1'b0})
        `CHK(stack_peer_i.got.size(), 1)
        rd(32'h0000_0014);
        `CHK(d, 32'h0000_0025)
        wr(32'h0000_0010, 32'h0000_0000);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b0)
        wr(32'h0000_0010, 32'h0000_0080);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'b1)
        wr(32'h0000_000C, 32'h0000_0080);
        repeat (2) @(posedge aclk);
        rd(32'h0000_000C);
        `CHK({irq, d}, {1'b0, 32'h0000_0000})
      end
    end
    // Slave enabled with no sync, then sync present and lost while enabled
    rst();
    wr(32'h0000_0010, 32'h0000_0040);
    wr(32'h0000_0000, 32'h0000_0006);
    wait_irq(20);
    `CHK(conv_enable, 1'b0)
    wr(32'h0000_0000, 32'h0000_0002);
    wr(32'h0000_000C, 32'h0000_0040);
    sync_run <= 1'b1;
    repeat (20) @(posedge aclk);
    wr(32'h0000_0000, 32'h0000_0006);
    repeat (4) @(posedge aclk);
    `CHK({irq, conv_enable}, 2'b01)
    sync_run <= 1'b0;
    wait_irq(1100);
    `CHK({irq, conv_enable}, 2'b10)
    conclude();
  end
endmodule : stack_strap_config_loader_bench
